// ==== rtl/embs_defines.svh ====
`ifndef EMBS_DEFINES_SVH
`define EMBS_DEFINES_SVH

`define MC_CLKS          12
`define MC_LAST          4'hb
`define HALF_LAST        3'h5
`define ALE_CLKS         3'h2
`define RST_HOLD_CYCLES  2
`define RST_HOLD_CLKS    (`RST_HOLD_CYCLES * `MC_CLKS)
`define RST_HOLD_W       5
`define WDT_RESET_CLKS   24
`define BOOT_LAST        3'h7
`define QUIET_BIT        5
`define INT_PROG_BYTES   17'h10000
`define RW_FIRST         4'h2
`define RW_LAST          4'h9
`define WDATA_LAST       4'ha

`endif

// ==== rtl/embs_pkg.sv ====
package embs_pkg;

	typedef enum logic [3:0] {
		ST_HALT  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_DATA  = 4'b0100,
		ST_IDLE  = 4'b1000
	} embs_state_t;

endpackage

// ==== rtl/embs_strobes.sv ====
`timescale 1ns/10ps
`include "embs_defines.svh"
module embs_strobes #(
	parameter int          WDT_RESET_CLKS = `WDT_RESET_CLKS,
	parameter logic [16:0] INT_PROG_BYTES = `INT_PROG_BYTES
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_rst_pin,
	output logic             o_rst_pin_o,
	output logic             o_rst_pin_oe,
	output logic             o_internal_reset,
	input  wire logic        i_wdt_overflow,
	input  wire logic        i_external_access_select,
	output logic             o_ext_prog,
	input  wire logic        i_power_control_reg_wr,
	input  wire logic [7:0]  i_power_control_reg_wdata,
	output logic             o_quiet_latch_mode,
	input  wire logic        i_idle,
	input  wire logic        i_power_down,
	input  wire logic        i_fetch_req,
	input  wire logic [15:0] i_fetch_addr,
	output logic      [7:0]  o_fetch_data,
	output logic             o_fetch_valid,
	input  wire logic        i_data_move_req,
	input  wire logic        i_data_move_write,
	input  wire logic        i_data_move_wide,
	input  wire logic [15:0] i_data_move_addr,
	input  wire logic [7:0]  i_data_move_wdata,
	output logic             o_data_move_ack,
	output logic      [7:0]  o_read_data,
	output logic             o_read_valid,
	output logic             o_addr_latch_strobe,
	output logic             o_program_store_strobe_n,
	input  wire logic [7:0]  i_low_addr_data_bus,
	output logic      [7:0]  o_low_addr_data_bus,
	output logic      [7:0]  o_low_addr_data_bus_oe,
	output logic             o_low_bus_pullup_en,
	output logic      [7:0]  o_high_addr_bus,
	output logic             o_high_addr_bus_oe,
	output logic             o_data_wr_strobe_n,
	output logic             o_data_rd_strobe_n
);
	embs_pkg::embs_state_t state;
	embs_pkg::embs_state_t next_state;

	logic [3:0]               phase;
	logic [2:0]               sub;
	logic                     half;
	logic                     rst_pin_s;
	logic                     ea_s;
	logic [7:0]               bus_s;
	logic [`RST_HOLD_W-1:0]   pin_hold_cnt;
	logic                     pin_reset;
	logic [15:0]              wdt_cnt;
	logic [15:0]              next_wdt_cnt;
	logic [2:0]               boot_cnt;
	logic                     quiet;
	logic                     ext_prog;
	logic [15:0]              f_addr;
	logic                     f_ext;
	logic                     f_above;
	logic                     fetch_pend;
	logic [15:0]              d_addr;
	logic [7:0]               d_wdata;
	logic                     d_write;
	logic                     d_wide;
	logic                     next_ale;
	logic                     next_program_store_strobe_n;
	logic [7:0]               next_low;
	logic                     next_low_oe;
	logic [7:0]               next_high;
	logic                     next_high_oe;

	wire internal_reset;
	wire wdt_reset;
	wire boot;
	wire cycle_end;
	wire half_end;
	wire ale_window;
	wire rw_window;
	wire wdata_window;
	wire in_fetch;
	wire in_data;
	wire ale_quiet;
	wire idle_level;
	wire next_pullup;
	wire next_rd_n;
	wire next_wr_n;
	wire next_fetch_valid;
	wire next_read_valid;
	wire hold_done;

	// true when the address lies beyond the on-chip program store
	function automatic logic above_internal(input logic [15:0] addr);
		above_internal = ({1'b0, addr} >= INT_PROG_BYTES);
	endfunction

	embs_sync3 #(
		.WIDTH(1)
	) u_sync_rst (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_async  (i_rst_pin),
		.o_stable (rst_pin_s)
	);

	// the select pin is trusted to be driven, so no float handling is done
	embs_sync3 #(
		.WIDTH(1)
	) u_sync_ea (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_async  (i_external_access_select),
		.o_stable (ea_s)
	);

	embs_sync3 #(
		.WIDTH(8)
	) u_sync_bus (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_async  (i_low_addr_data_bus),
		.o_stable (bus_s)
	);

	embs_timing u_timing (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_clear (internal_reset),
		.o_phase (phase),
		.o_sub   (sub),
		.o_half  (half)
	);

	// boot keeps the device in reset until the synchronisers have settled
	assign boot           = (boot_cnt != `BOOT_LAST);
	assign wdt_reset      = (wdt_cnt != 16'h0);
	assign internal_reset = pin_reset | wdt_reset | boot;
	assign hold_done      = (pin_hold_cnt == `RST_HOLD_W'(`RST_HOLD_CLKS - 1));

	assign next_wdt_cnt = i_wdt_overflow ? WDT_RESET_CLKS[15:0] :
		(wdt_reset ? wdt_cnt - 16'h1 : 16'h0);

	assign cycle_end    = (phase == `MC_LAST);
	assign half_end     = (sub == `HALF_LAST);
	assign ale_window   = (sub < `ALE_CLKS);
	assign rw_window    = (phase >= `RW_FIRST) && (phase <= `RW_LAST);
	assign wdata_window = (phase >= `RW_FIRST) && (phase <= `WDATA_LAST);
	assign in_fetch     = (state == embs_pkg::ST_FETCH);
	assign in_data      = (state == embs_pkg::ST_DATA);

	// quiet only bites while running internal code below the internal size
	assign ale_quiet  = quiet & ~ext_prog & ~f_above;
	assign idle_level = i_idle & ~i_power_down;

	assign next_pullup      = ((in_fetch & f_ext) | in_data) & ~internal_reset;
	assign next_rd_n        = ~(in_data & ~d_write & rw_window);
	assign next_wr_n        = ~(in_data & d_write & rw_window);
	// the pin synchroniser delays data, so the byte is taken early in the next half
	assign next_fetch_valid = fetch_pend & (sub == 3'h1);
	assign next_read_valid  = in_data & ~d_write & (phase == `RW_LAST);

	assign o_data_move_ack = cycle_end & ~internal_reset & ~i_idle & ~i_power_down
		& i_data_move_req;
	assign o_rst_pin_o        = 1'b1;
	assign o_internal_reset   = internal_reset;
	assign o_ext_prog         = ext_prog;
	assign o_quiet_latch_mode = quiet;

	always_comb begin
		next_state = state;
		case (state)
			embs_pkg::ST_HALT,
			embs_pkg::ST_FETCH,
			embs_pkg::ST_DATA,
			embs_pkg::ST_IDLE: begin
				if (cycle_end) begin
					if (i_idle || i_power_down) begin
						next_state = embs_pkg::ST_IDLE;
					end else if (i_data_move_req) begin
						next_state = embs_pkg::ST_DATA;
					end else begin
						next_state = embs_pkg::ST_FETCH;
					end
				end
			end
			default: begin
				next_state = embs_pkg::ST_HALT;
			end
		endcase
		if (internal_reset) begin
			next_state = embs_pkg::ST_HALT;
		end
	end

	always_comb begin
		next_ale     = 1'b0;
		next_program_store_strobe_n  = 1'b1;
		next_low     = 8'h00;
		next_low_oe  = 1'b0;
		next_high    = 8'h00;
		next_high_oe = 1'b0;
		case (state)
			embs_pkg::ST_FETCH: begin
				// one latch pulse per half unless ale_quiet, two strobe pulses per cycle when f_ext
				next_ale    = ale_window & ~ale_quiet;
				next_program_store_strobe_n = ~(f_ext & ~ale_window);
				if (f_ext && ale_window) begin
					next_low    = f_addr[7:0];
					next_low_oe = 1'b1;
				end
				next_high    = f_addr[15:8];
				next_high_oe = f_ext;
			end
			embs_pkg::ST_DATA: begin
				// second latch pulse and both strobe pulses are skipped
				next_ale    = ale_window & ~half;
				next_program_store_strobe_n = 1'b1;
				if (ale_window && !half) begin
					next_low    = d_addr[7:0];
					next_low_oe = 1'b1;
				end else if (d_write && wdata_window) begin
					next_low    = d_wdata;
					next_low_oe = 1'b1;
				end
				next_high    = d_addr[15:8];
				next_high_oe = d_wide;
			end
			embs_pkg::ST_IDLE: begin
				next_ale = idle_level;
			end
			embs_pkg::ST_HALT: begin
				next_ale = 1'b0;
			end
			default: begin
				next_ale = 1'b0;
			end
		endcase
		// a half cut by reset must not leave the latch strobe, program strobe or drivers active; read and write strobes follow the state
		if (internal_reset) begin
			next_ale     = 1'b0;
			next_program_store_strobe_n  = 1'b1;
			next_low_oe  = 1'b0;
			next_high_oe = 1'b0;
		end
	end

	// reset pin must stay high for two whole machine cycles
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_hold_cnt <= '0;
			pin_reset    <= 1'b0;
		end else if (!rst_pin_s) begin
			pin_hold_cnt <= '0;
			pin_reset    <= 1'b0;
		end else if (hold_done) begin
			pin_reset <= 1'b1;
		end else begin
			pin_hold_cnt <= pin_hold_cnt + `RST_HOLD_W'(1);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wdt_cnt      <= 16'h0;
			o_rst_pin_oe <= 1'b0;
			boot_cnt     <= 3'h0;
		end else begin
			wdt_cnt      <= next_wdt_cnt;
			o_rst_pin_oe <= (next_wdt_cnt != 16'h0);
			boot_cnt     <= boot ? boot_cnt + 3'h1 : boot_cnt;
		end
	end

	// select pin is latched only while reset is active, ignored afterwards
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_prog <= 1'b0;
			quiet    <= 1'b0;
		end else begin
			if (internal_reset) begin
				ext_prog <= ~ea_s;
			end
			if (internal_reset) begin
				quiet <= 1'b0;
			end else if (i_power_control_reg_wr) begin
				quiet <= i_power_control_reg_wdata[`QUIET_BIT];
			end
		end
	end

	// requests are captured one clock ahead so each half starts with stable values
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state   <= embs_pkg::ST_HALT;
			f_addr  <= 16'h0;
			f_ext   <= 1'b0;
			f_above <= 1'b0;
			fetch_pend <= 1'b0;
			d_addr  <= 16'h0;
			d_wdata <= 8'h00;
			d_write <= 1'b0;
			d_wide  <= 1'b0;
		end else begin
			state <= next_state;
			if (half_end) begin
				fetch_pend <= in_fetch & f_ext;
				f_addr  <= i_fetch_addr;
				f_ext   <= i_fetch_req & (ext_prog | above_internal(i_fetch_addr));
				f_above <= above_internal(i_fetch_addr);
			end
			if (o_data_move_ack) begin
				d_addr  <= i_data_move_addr;
				d_wdata <= i_data_move_wdata;
				d_write <= i_data_move_write;
				d_wide  <= i_data_move_wide;
			end
		end
	end

	// pins come from flops so they never glitch during decode changes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_addr_latch_strobe      <= 1'b0;
			o_program_store_strobe_n <= 1'b1;
			o_low_addr_data_bus      <= 8'h00;
			o_low_addr_data_bus_oe   <= 8'h00;
			o_low_bus_pullup_en      <= 1'b0;
			o_high_addr_bus          <= 8'h00;
			o_high_addr_bus_oe       <= 1'b0;
			o_data_wr_strobe_n       <= 1'b1;
			o_data_rd_strobe_n       <= 1'b1;
		end else begin
			o_addr_latch_strobe      <= next_ale;
			o_program_store_strobe_n <= next_program_store_strobe_n;
			o_low_addr_data_bus      <= next_low;
			o_low_addr_data_bus_oe   <= {8{next_low_oe}};
			o_low_bus_pullup_en      <= next_pullup;
			o_high_addr_bus          <= next_high;
			o_high_addr_bus_oe       <= next_high_oe;
			o_data_wr_strobe_n       <= next_wr_n;
			o_data_rd_strobe_n       <= next_rd_n;
		end
	end

	// read data passes the pin synchroniser, so memory must settle early in the strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fetch_data  <= 8'h00;
			o_fetch_valid <= 1'b0;
			o_read_data   <= 8'h00;
			o_read_valid  <= 1'b0;
		end else begin
			o_fetch_valid <= next_fetch_valid;
			o_read_valid  <= next_read_valid;
			if (next_fetch_valid) begin
				o_fetch_data <= bus_s;
			end
			if (next_read_valid) begin
				o_read_data <= bus_s;
			end
		end
	end
endmodule

// ==== rtl/embs_sync3.sv ====
`timescale 1ns/10ps
module embs_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_stable
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	wire  [WIDTH-1:0] agree;
	wire  [WIDTH-1:0] next_stable;

	// a bit changes only once the second and third stages agree
	assign agree       = ~(s2 ^ s3);
	assign next_stable = (o_stable & ~agree) | (s3 & agree);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1       <= '0;
			s2       <= '0;
			s3       <= '0;
			o_stable <= '0;
		end else begin
			s1       <= i_async;
			s2       <= s1;
			s3       <= s2;
			o_stable <= next_stable;
		end
	end
endmodule

// ==== rtl/embs_timing.sv ====
`timescale 1ns/10ps
`include "embs_defines.svh"
module embs_timing (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_clear,
	output logic      [3:0] o_phase,
	output logic      [2:0] o_sub,
	output logic            o_half
);
	wire cycle_end;
	wire half_end;

	assign cycle_end = (o_phase == `MC_LAST);
	assign half_end  = (o_sub == `HALF_LAST);

	// synchronous clear keeps the phase counter aligned to reset release
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_phase <= 4'h0;
			o_sub   <= 3'h0;
			o_half  <= 1'b0;
		end else if (i_clear || cycle_end) begin
			o_phase <= 4'h0;
			o_sub   <= 3'h0;
			o_half  <= 1'b0;
		end else begin
			o_phase <= o_phase + 4'h1;
			o_sub   <= half_end ? 3'h0 : o_sub + 3'h1;
			o_half  <= half_end ? 1'b1 : o_half;
		end
	end
endmodule

// ==== sim/embs_ext_mem.sv ====
`timescale 1ns/10ps
module embs_ext_mem (
	input  wire logic       i_clk,
	input  wire logic       i_ale,
	input  wire logic       i_program_store_strobe_n,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	input  wire logic [7:0] i_lo,
	input  wire logic [7:0] i_lo_oe,
	input  wire logic       i_pu,
	input  wire logic [7:0] i_hi,
	input  wire logic       i_hi_oe,
	output logic      [7:0] o_lo
);
	logic [15:0] addr;
	logic [7:0]  mem [0:255];
	logic [7:0]  last = 8'h00;
	wire  [7:0]  rdat = !i_program_store_strobe_n ? addr[15:8] ^ addr[7:0] ^ 8'h5a : mem[addr[7:0]];
	// released bus without the pullup flips every cycle so a late sample cannot pass by luck
	assign o_lo = (i_lo_oe != 8'h00) ? i_lo : (!i_program_store_strobe_n || !i_rd_n) ? rdat : i_pu ? 8'hff : ~last;
	always @(posedge i_clk) begin
		if (i_ale)
			addr <= {i_hi_oe ? i_hi : 8'h00, o_lo};
		if (!i_wr_n)
			mem[addr[7:0]] <= o_lo;
		last <= o_lo;
	end
endmodule

// ==== sim/embs_strobes_props.sv ====
`timescale 1ns/10ps
module embs_strobes_props #(
	parameter int WDT_RESET_CLKS = 24
) (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_rst_pin,
	input wire logic       i_wdt_overflow,
	input wire logic       i_idle,
	input wire logic       i_power_down,
	input wire logic       o_rst_pin_oe,
	input wire logic       o_internal_reset,
	input wire logic       o_ext_prog,
	input wire logic       o_quiet_latch_mode,
	input wire logic       o_addr_latch_strobe,
	input wire logic       o_program_store_strobe_n,
	input wire logic       o_data_rd_strobe_n,
	input wire logic       o_data_wr_strobe_n,
	input wire logic       o_low_bus_pullup_en,
	input wire logic [7:0] o_low_addr_data_bus_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [4:0] pin_cnt;
	logic [4:0] md_cnt;
	logic [5:0] wdt_cnt;
	// saturating run lengths, so long holds never wrap into a false pass
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_cnt <= 5'h0;
			md_cnt <= 5'h0;
			wdt_cnt <= 6'h0;
		end else begin
			pin_cnt <= !i_rst_pin ? 5'h0 : pin_cnt + 5'(pin_cnt != 5'h1f);
			md_cnt <= !(i_idle || i_power_down) ? 5'h0 : md_cnt + 5'(md_cnt != 5'h1f);
			wdt_cnt <= !o_rst_pin_oe ? 6'h0 : wdt_cnt + 6'(wdt_cnt != 6'h3f);
		end
	end
	sequence program_store_strobe_low4;
		!o_program_store_strobe_n [*4] ##1 o_program_store_strobe_n;
	endsequence
	sequence low_run8(logic s);
		!s [*8] ##1 s;
	endsequence
	sequence ale_pair;
		o_addr_latch_strobe [*2] ##1 !o_addr_latch_strobe;
	endsequence
	chk_pin_reset_hold: assert property (pin_cnt >= 5'h1e |-> o_internal_reset)
		else $error("pin reset not taken");
	chk_wdt_pin_drive: assert property (i_wdt_overflow |=> o_rst_pin_oe && o_internal_reset)
		else $error("reset pin not driven after overflow");
	chk_wdt_pin_len: assert property (wdt_cnt <= WDT_RESET_CLKS + 1)
		else $error("reset pin driven too long");
	chk_program_store_strobe_pulse: assert property ($fell(o_program_store_strobe_n) |-> program_store_strobe_low4)
		else $error("program strobe pulse shape wrong");
	chk_program_store_strobe_skip: assert property (!o_data_rd_strobe_n || !o_data_wr_strobe_n
		|-> o_program_store_strobe_n)
		else $error("program strobe during data access");
	chk_program_store_strobe_reset: assert property (o_internal_reset |-> o_program_store_strobe_n)
		else $error("program strobe active in reset");
	chk_ale_width: assert property ($rose(o_addr_latch_strobe) && !i_idle && !i_power_down
		|-> ale_pair)
		else $error("latch strobe width wrong");
	chk_ext_prog_hold: assert property (!o_internal_reset && !$past(o_internal_reset)
		|-> $stable(o_ext_prog))
		else $error("program source changed after reset");
	chk_bus_quiet: assert property (o_internal_reset && $past(o_internal_reset, 2)
		|-> !o_low_bus_pullup_en && o_low_addr_data_bus_oe == 8'h00)
		else $error("low bus active in reset");
	chk_quiet_clear: assert property (o_internal_reset && $past(o_internal_reset)
		|-> !o_quiet_latch_mode)
		else $error("quiet mode survived reset");
	chk_idle_level: assert property (md_cnt >= 5'h1a && o_quiet_latch_mode && !o_internal_reset
		|-> o_addr_latch_strobe == ($past(i_idle) && !$past(i_power_down)))
		else $error("latch strobe level wrong in low power");
	chk_rd_width: assert property ($fell(o_data_rd_strobe_n) |-> low_run8(o_data_rd_strobe_n))
		else $error("read strobe width wrong");
	chk_wr_width: assert property ($fell(o_data_wr_strobe_n) |-> low_run8(o_data_wr_strobe_n))
		else $error("write strobe width wrong");
endmodule
bind embs_strobes embs_strobes_props #(.WDT_RESET_CLKS(WDT_RESET_CLKS)) u_props (.*);

// ==== sim/embs_strobes_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
module embs_strobes_tb;
	logic        i_clk, i_rst, i_rst_pin, i_wdt_overflow, i_external_access_select;
	logic        i_power_control_reg_wr, i_idle, i_power_down, i_fetch_req;
	logic        i_data_move_req, i_data_move_write, i_data_move_wide;
	logic [7:0]  i_power_control_reg_wdata, i_data_move_wdata, o_fetch_data, o_read_data;
	logic [15:0] i_fetch_addr, i_data_move_addr;
	wire  [7:0]  i_low_addr_data_bus;
	logic        o_rst_pin_o, o_rst_pin_oe, o_internal_reset, o_ext_prog, o_quiet_latch_mode;
	logic        o_fetch_valid, o_data_move_ack, o_read_valid, o_addr_latch_strobe;
	logic        o_program_store_strobe_n, o_low_bus_pullup_en, o_high_addr_bus_oe;
	logic        o_data_wr_strobe_n, o_data_rd_strobe_n, ale_q, ps_q;
	logic [7:0]  o_low_addr_data_bus, o_low_addr_data_bus_oe, o_high_addr_bus;
	int          error_cnt = 0, tests_run = 0, ale_n, ps_n, wr_lo, rd_lo;
	embs_strobes #(.WDT_RESET_CLKS(4), .INT_PROG_BYTES(17'h1000)) uut (.*);
	embs_ext_mem mem (.i_clk(i_clk), .i_ale(o_addr_latch_strobe),
		.i_program_store_strobe_n(o_program_store_strobe_n), .i_rd_n(o_data_rd_strobe_n),
		.i_wr_n(o_data_wr_strobe_n), .i_lo(o_low_addr_data_bus),
		.i_lo_oe(o_low_addr_data_bus_oe), .i_pu(o_low_bus_pullup_en), .i_hi(o_high_addr_bus),
		.i_hi_oe(o_high_addr_bus_oe), .o_lo(i_low_addr_data_bus));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		ale_q <= o_addr_latch_strobe;
		ps_q <= o_program_store_strobe_n;
		if (o_addr_latch_strobe && !ale_q)
			ale_n++;
		if (!o_program_store_strobe_n && ps_q)
			ps_n++;
		if (o_data_wr_strobe_n === 1'b0)
			wr_lo++;
		if (o_data_rd_strobe_n === 1'b0)
			rd_lo++;
	end
	task automatic win(input int n);
		ale_n = 0;
		ps_n = 0;
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic run_wait();
		for (int k = 0; k < 60 && o_internal_reset !== 1'b0; k++)
			@(posedge i_clk);
		#1;
		`CHK("run", 1'b0, o_internal_reset)
	endtask
	task automatic do_reset(input logic sel);
		i_external_access_select = sel;
		i_rst = 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		run_wait();
		`CHK("ext_prog", ~sel, o_ext_prog)
		`CHK("quiet", 1'b0, o_quiet_latch_mode)
	endtask
	task automatic set_quiet(input logic [7:0] d);
		i_power_control_reg_wdata = d;
		i_power_control_reg_wr = 1'b1;
		@(posedge i_clk);
		#1;
		i_power_control_reg_wr = 1'b0;
		@(posedge i_clk);
		#1;
		`CHK("quiet", d[5], o_quiet_latch_mode)
	endtask
	task automatic t_fetch(input logic [15:0] a, input int ale_e, input int ps_e);
		i_fetch_addr = a;
		win(24);
		win(120);
		`CHK("ale_cnt", ale_e, ale_n)
		`CHK("program_store_strobe_cnt", ps_e, ps_n)
	endtask
	task automatic move(input logic wr, input logic wide, input logic [15:0] a,
		input logic [7:0] d);
		logic [7:0] got;
		got = 8'hxx;
		{i_data_move_write, i_data_move_wide, i_data_move_addr} = {wr, wide, a};
		i_data_move_wdata = d;
		i_data_move_req = 1'b1;
		for (int k = 0; k < 30 && o_data_move_ack !== 1'b1; k++)
			@(negedge i_clk);
		`CHK("ack", 1'b1, o_data_move_ack)
		@(posedge i_clk);
		#1;
		i_data_move_req = 1'b0;
		{ale_n, ps_n, wr_lo, rd_lo} = '0;
		repeat (13) begin
			@(posedge i_clk);
			#1;
			if (o_read_valid === 1'b1)
				got = o_read_data;
		end
		`CHK("ale_move", 1, ale_n)
		`CHK("program_store_strobe_move", 0, ps_n)
		`CHK("wr_low", wr ? 8 : 0, wr_lo)
		`CHK("rd_low", wr ? 0 : 8, rd_lo)
		if (!wr)
			`CHK("rdata", d, got)
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#30000;
		error_cnt++;
		finish_test();
	end
	initial begin
		{i_rst_pin, i_wdt_overflow, i_power_control_reg_wr, i_idle, i_power_down} = '0;
		{i_data_move_req, i_data_move_write, i_data_move_wide, i_data_move_addr} = '0;
		{i_power_control_reg_wdata, i_data_move_wdata} = '0;
		i_fetch_req = 1'b1;
		i_fetch_addr = 16'h0123;
		do_reset(1'b1);
		`CHK("program_store_strobe_idle", 1'b1, o_program_store_strobe_n)
		t_fetch(16'h0123, 20, 0);
		set_quiet(8'h20);
		t_fetch(16'h0123, 0, 0);
		`CHK("ale_quiet", 1'b0, o_addr_latch_strobe)
		t_fetch(16'h2345, 20, 20);
		@(posedge o_fetch_valid);
		#1;
		`CHK("fetch", 8'h23 ^ 8'h45 ^ 8'h5a, o_fetch_data)
		i_fetch_addr = 16'h0100;
		move(1'b1, 1'b1, 16'h1234, 8'ha5);
		move(1'b0, 1'b0, 16'h0034, 8'ha5);
		move(1'b1, 1'b0, 16'h0077, 8'h3c);
		move(1'b0, 1'b1, 16'hff77, 8'h3c);
		i_idle = 1'b1;
		win(30);
		`CHK("ale_idle", 1'b1, o_addr_latch_strobe)
		{i_idle, i_power_down} = 2'b01;
		win(30);
		`CHK("ale_pd", 1'b0, o_addr_latch_strobe)
		{i_wdt_overflow, i_power_down} = 2'b10;
		@(posedge i_clk);
		#1;
		i_wdt_overflow = 1'b0;
		`CHK("pin_drive", 2'b11, {o_rst_pin_oe, o_rst_pin_o})
		repeat (6) @(posedge i_clk);
		#1;
		`CHK("pin_free", 1'b0, o_rst_pin_oe)
		run_wait();
		`CHK("quiet_rst", 1'b0, o_quiet_latch_mode)
		i_rst_pin = 1'b1;
		win(10);
		i_rst_pin = 1'b0;
		win(6);
		`CHK("short_pin", 1'b0, o_internal_reset)
		i_rst_pin = 1'b1;
		win(40);
		`CHK("pin_rst", 1'b1, o_internal_reset)
		i_rst_pin = 1'b0;
		run_wait();
		do_reset(1'b0);
		set_quiet(8'h20);
		t_fetch(16'h0100, 20, 20);
		move(1'b0, 1'b1, 16'h1234, 8'ha5);
		finish_test();
	end
endmodule
